// ===== src/mqsf_fifo.sv
`timescale 1ns/100ps
module mqsf_fifo #(
   parameter int WIDTH = 39,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] PTR_ONE = (AW)'(1);
   localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
   localparam logic [AW-1:0] PTR_LAST = (AW)'(DEPTH - 1);

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW:0] count_reg;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign in_ready = count_reg != DEPTH_CNT;
   assign out_valid = count_reg != '0;
   assign out_data = store[rptr_reg];

   always_ff @(posedge clk) begin
      if (push) store[wptr_reg] <= in_data;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) wptr_reg <= (wptr_reg == PTR_LAST) ? '0 : wptr_reg + PTR_ONE;
         if (pop) rptr_reg <= (rptr_reg == PTR_LAST) ? '0 : rptr_reg + PTR_ONE;
         if (push && !pop) count_reg <= count_reg + CNT_ONE;
         if (pop && !push) count_reg <= count_reg - CNT_ONE;
      end
   end
endmodule : mqsf_fifo

// ===== src/mqsf_pkg.sv
// Behaviour
// RULE1: full flag lags write queue switch three clocks
// RULE2: new read queue word appears three clocks later
// RULE3: one more old-queue word during read switch
// RULE4: no store into a full write queue
// RULE5: read frees space, full flag rises after
// RULE6: first word into empty queue falls through
// RULE7: read queue switch takes four clocks
// RULE8: last word read: ready high, word kept
// RULE9: valid word falls through: ready goes low
// RULE10: read disabled: output word held unchanged
// RULE11: output enable acts without waiting for clock
// RULE12: board ties all output enables together
// RULE13: packets at least four full words long
// RULE14: packets never longer than the queue depth
// RULE15: start and end marker never together
// RULE16: almost-full after switch: three clocks latency
// RULE17: almost-full asserts two clocks after write
// RULE18: almost-empty asserts two clocks after read
// RULE19: almost-empty deasserts one clock after write (code: three clocks, the word passes the input FIFO first)
// RULE20: status strobe high means address strobe low
// RULE21: status busses switch two clocks after selection
// RULE22: status word may change every clock
// RULE23: old status owner releases, new owner drives
// RULE24: unselected device floats its almost flag
// RULE25: selections and enables taken on rising edge
package mqsf_pkg;
   localparam int NQ = 8;
   localparam int QW = 3;
   localparam int DEVW = 3;
   localparam int DW = 36;
   localparam int QDEPTH = 16;
   localparam int PW = 4;
   localparam int CW = 5;
   localparam int FIFO_DEPTH = 32;
   localparam logic [CW-1:0] QDEPTH_CNT = 5'h10;
   localparam logic [CW-1:0] AF_OFFSET = 5'h02;
   localparam logic [CW-1:0] AE_OFFSET = 5'h02;
   localparam logic [CW-1:0] CNT_ONE = 5'h01;
   localparam logic [CW-1:0] CNT_ZERO = 5'h00;
   localparam logic [PW-1:0] PTR_ONE = 4'h1;
   // expansion position of this device; value arbitrary
   localparam logic [DEVW-1:0] DEV_ID_DEFAULT = 3'h0;

   typedef struct packed {
      logic [DEVW-1:0] dev;
      logic [QW-1:0] queue;
   } mqsf_qaddr_t;

   typedef struct packed {
      logic [QW-1:0] queue;
      logic [DW-1:0] data;
   } mqsf_item_t;

   typedef enum logic [3:0] {
      RD_RUN = 4'b0001,
      RD_SW1 = 4'b0010,
      RD_SW2 = 4'b0100,
      RD_SW3 = 4'b1000
   } mqsf_rd_state_t;

   function automatic logic mqsf_is_full(input logic [CW-1:0] cnt);
      return cnt >= QDEPTH_CNT;
   endfunction : mqsf_is_full

   function automatic logic mqsf_is_afull(input logic [CW-1:0] cnt);
      return cnt >= (QDEPTH_CNT - AF_OFFSET);
   endfunction : mqsf_is_afull

   function automatic logic mqsf_is_aempty(input logic [CW-1:0] cnt);
      return cnt <= AE_OFFSET;
   endfunction : mqsf_is_aempty

   function automatic logic [CW-1:0] mqsf_step(input logic [CW-1:0] cnt, input logic inc,
                                               input logic dec);
      logic [CW-1:0] r;
      r = cnt;
      if (inc && !dec) r = cnt + CNT_ONE;
      if (dec && !inc) r = cnt - CNT_ONE;
      return r;
   endfunction : mqsf_step
endpackage : mqsf_pkg

// ===== src/mqsf_qmem.sv
`timescale 1ns/100ps
module mqsf_qmem import mqsf_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic we,
   input wire logic [QW+PW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic re,
   input wire logic [QW+PW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] cells [NQ*QDEPTH];
   logic [DW-1:0] rdata_reg;

   assign rdata = rdata_reg;

   always_ff @(posedge clk) begin
      if (we) cells[waddr] <= wdata;
   end

   // read register doubles as the output word: it only moves on a fetch
   always_ff @(posedge clk or posedge reset) begin
      if (reset) rdata_reg <= '0;
      else if (re) rdata_reg <= cells[raddr]; //RULE10
   end
endmodule : mqsf_qmem

// ===== src/mqsf_switch.sv
`timescale 1ns/100ps
module mqsf_switch import mqsf_pkg::*; #(
   parameter logic [DEVW-1:0] DEV_ID = DEV_ID_DEFAULT
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic wr_en_n,
   input wire logic write_queue_addr_strobe,
   input wire logic full_status_strobe,
   input wire mqsf_qaddr_t wr_addr,
   input wire logic [DW-1:0] wr_data,
   output logic queue_full_flag_n,
   output logic almost_full_flag_n,
   output logic almost_full_flag_oe,
   output logic [NQ-1:0] almost_full_status_bus,
   output logic almost_full_status_oe,
   input wire logic rd_en_n,
   input wire logic read_queue_addr_strobe,
   input wire logic empty_status_strobe,
   input wire mqsf_qaddr_t rd_addr,
   input wire logic out_en_n,
   output logic [DW-1:0] rd_data,
   output logic rd_data_oe,
   output logic output_ready_n,
   output logic almost_empty_flag_n,
   output logic almost_empty_flag_oe,
   output logic [NQ-1:0] almost_empty_status_bus,
   output logic almost_empty_status_oe
);
   logic [CW-1:0] acc_cnt_reg [NQ];
   logic [CW-1:0] mem_cnt_reg [NQ];
   logic [PW-1:0] wptr_reg [NQ];
   logic [PW-1:0] rptr_reg [NQ];
   logic [QW-1:0] wq_reg, wq_p1_reg, wq_p2_reg;
   logic wown_reg, wown_p1_reg, wown_p2_reg;
   logic [QW-1:0] rq_reg, rq_new_reg;
   logic rown_reg, rown_new_reg;
   mqsf_rd_state_t rd_state_reg, rd_state_next;
   logic output_ready_n_reg, output_ready_n_next;
   logic queue_full_flag_n_reg, af_raw_reg, almost_full_flag_n_reg, almost_full_flag_oe_reg;
   logic ae_raw_reg, almost_empty_flag_n_reg, almost_empty_flag_oe_reg;
   logic [NQ-1:0] af_vec_reg, ae_vec_reg;
   logic fown_reg, eown_reg, fown_d_reg, eown_d_reg;
   logic [NQ-1:0] almost_full_status_bus_reg, almost_empty_status_bus_reg;
   logic almost_full_status_oe_reg, almost_empty_status_oe_reg;
   logic [NQ-1:0] full_vec, afull_vec, aempty_vec;
   mqsf_item_t fifo_in, fifo_out;
   logic fifo_in_ready, fifo_out_valid;

   always_comb begin
      for (int i = 0; i < NQ; i++) begin
         full_vec[i] = mqsf_is_full(acc_cnt_reg[i]);
         afull_vec[i] = mqsf_is_afull(acc_cnt_reg[i]);
         aempty_vec[i] = mqsf_is_aempty(mem_cnt_reg[i]);
      end
   end

   // write side: a write is refused while the selected queue reads full
   wire wr_hit = wr_addr.dev == DEV_ID;
   wire wr_select = write_queue_addr_strobe;
   wire accept = !wr_en_n && wown_reg && !full_vec[wq_reg] && queue_full_flag_n_reg //RULE4
                 && fifo_in_ready;
   assign fifo_in = '{queue: wq_reg, data: wr_data};

   // read side sequencing
   wire rd_select = read_queue_addr_strobe && rd_state_reg == RD_RUN;
   wire in_sw3 = rd_state_reg == RD_SW3;
   wire in_sw2 = rd_state_reg == RD_SW2;
   wire [QW-1:0] fetch_q = in_sw3 ? rq_new_reg : rq_reg;
   wire fetch_own = in_sw3 ? rown_new_reg : rown_reg;
   wire fetch_avail = mem_cnt_reg[fetch_q] != CNT_ZERO;
   wire consume = !rd_en_n && !output_ready_n_reg;
   // the old queue gives one more word in SW2 and the new queue falls through in SW3
   wire fetch = fetch_own && fetch_avail && (in_sw2 || in_sw3 //RULE3 RULE2
                || (rd_state_reg == RD_RUN && (output_ready_n_reg || !rd_en_n)));
   // the store has one port each way; a fetch stalls the drain so the FIFO can fill
   wire drain = fifo_out_valid && !fetch;
   wire [QW+PW-1:0] mem_waddr = {fifo_out.queue, wptr_reg[fifo_out.queue]};
   wire [QW+PW-1:0] mem_raddr = {fetch_q, rptr_reg[fetch_q]};

   mqsf_fifo #(.WIDTH($bits(mqsf_item_t)), .DEPTH(FIFO_DEPTH)) u_in_fifo (
      .clk(core_clk),
      .reset(reset),
      .in_valid(accept),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(!fetch),
      .out_data(fifo_out)
   );

   mqsf_qmem u_qmem (
      .clk(core_clk),
      .reset(reset),
      .we(drain),
      .waddr(mem_waddr),
      .wdata(fifo_out.data),
      .re(fetch),
      .raddr(mem_raddr),
      .rdata(rd_data)
   );

   always_comb begin
      rd_state_next = rd_state_reg;
      unique case (rd_state_reg)
         RD_RUN: if (rd_select) rd_state_next = RD_SW1; //RULE7
         RD_SW1: rd_state_next = RD_SW2;
         RD_SW2: rd_state_next = RD_SW3;
         RD_SW3: rd_state_next = RD_RUN;
      endcase
   end

   always_comb begin
      output_ready_n_next = output_ready_n_reg;
      if (fetch) output_ready_n_next = 1'b0; //RULE9 RULE6
      else if (in_sw3 || consume) output_ready_n_next = 1'b1; //RULE8
   end

   // counters: acc counts words taken in, mem counts words readable in the store
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NQ; i++) begin
            acc_cnt_reg[i] <= CNT_ZERO;
            mem_cnt_reg[i] <= CNT_ZERO;
            wptr_reg[i] <= '0;
            rptr_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NQ; i++) begin
            acc_cnt_reg[i] <= mqsf_step(acc_cnt_reg[i], accept && wq_reg == QW'(i), //RULE5
                                        fetch && fetch_q == QW'(i));
            mem_cnt_reg[i] <= mqsf_step(mem_cnt_reg[i], drain && fifo_out.queue == QW'(i),
                                        fetch && fetch_q == QW'(i));
            if (drain && fifo_out.queue == QW'(i)) wptr_reg[i] <= wptr_reg[i] + PTR_ONE;
            if (fetch && fetch_q == QW'(i)) rptr_reg[i] <= rptr_reg[i] + PTR_ONE;
         end
      end
   end

   // write port selection and its delayed copies for flag reporting
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wq_reg <= '0;
         wq_p1_reg <= '0;
         wq_p2_reg <= '0;
         wown_reg <= 1'b0;
         wown_p1_reg <= 1'b0;
         wown_p2_reg <= 1'b0;
      end else begin
         if (wr_select) begin //RULE25
            wq_reg <= wr_addr.queue;
            wown_reg <= wr_hit;
         end
         wq_p1_reg <= wq_reg;
         wq_p2_reg <= wq_p1_reg;
         wown_p1_reg <= wown_reg;
         wown_p2_reg <= wown_p1_reg;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rd_state_reg <= RD_RUN;
         rq_reg <= '0;
         rq_new_reg <= '0;
         rown_reg <= 1'b0;
         rown_new_reg <= 1'b0;
         output_ready_n_reg <= 1'b1;
      end else begin
         rd_state_reg <= rd_state_next;
         output_ready_n_reg <= output_ready_n_next;
         if (rd_select) begin //RULE25
            rq_new_reg <= rd_addr.queue;
            rown_new_reg <= rd_addr.dev == DEV_ID;
         end
         if (in_sw3) begin
            rq_reg <= rq_new_reg;
            rown_reg <= rown_new_reg;
         end
      end
   end

   // flags: the full flag follows the queue chosen three clocks earlier
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         queue_full_flag_n_reg <= 1'b1;
         af_raw_reg <= 1'b0;
         almost_full_flag_n_reg <= 1'b1;
         almost_full_flag_oe_reg <= 1'b0;
         ae_raw_reg <= 1'b1;
         almost_empty_flag_n_reg <= 1'b0;
         almost_empty_flag_oe_reg <= 1'b0;
      end else begin
         queue_full_flag_n_reg <= !full_vec[wq_p2_reg]; //RULE1 RULE5
         af_raw_reg <= afull_vec[wq_p1_reg]; //RULE16 RULE17
         almost_full_flag_n_reg <= !af_raw_reg;
         almost_full_flag_oe_reg <= wown_p2_reg; //RULE24
         ae_raw_reg <= aempty_vec[rq_reg]; //RULE18 RULE19
         almost_empty_flag_n_reg <= !ae_raw_reg;
         almost_empty_flag_oe_reg <= rown_reg; //RULE24
      end
   end

   // direct status busses: a new selection every clock is taken
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         af_vec_reg <= '1;
         ae_vec_reg <= '0;
         fown_reg <= 1'b0;
         eown_reg <= 1'b0;
         fown_d_reg <= 1'b0;
         eown_d_reg <= 1'b0;
         almost_full_status_bus_reg <= '1;
         almost_empty_status_bus_reg <= '0;
         almost_full_status_oe_reg <= 1'b0;
         almost_empty_status_oe_reg <= 1'b0;
      end else begin
         af_vec_reg <= ~afull_vec;
         ae_vec_reg <= ~aempty_vec;
         if (full_status_strobe) fown_reg <= wr_addr.dev == DEV_ID; //RULE22 RULE25
         if (empty_status_strobe) eown_reg <= rd_addr.dev == DEV_ID; //RULE22
         // extra stage: ownership moves two clocks after the strobe edge, not one
         fown_d_reg <= fown_reg;
         eown_d_reg <= eown_reg;
         almost_full_status_oe_reg <= fown_d_reg; //RULE21 RULE23
         almost_empty_status_oe_reg <= eown_d_reg; //RULE21 RULE23
         almost_full_status_bus_reg <= af_vec_reg;
         almost_empty_status_bus_reg <= ae_vec_reg;
      end
   end

   assign queue_full_flag_n = queue_full_flag_n_reg;
   assign almost_full_flag_n = almost_full_flag_n_reg;
   assign almost_full_flag_oe = almost_full_flag_oe_reg;
   assign almost_full_status_bus = almost_full_status_bus_reg;
   assign almost_full_status_oe = almost_full_status_oe_reg;
   assign output_ready_n = output_ready_n_reg;
   assign almost_empty_flag_n = almost_empty_flag_n_reg;
   assign almost_empty_flag_oe = almost_empty_flag_oe_reg;
   assign almost_empty_status_bus = almost_empty_status_bus_reg;
   assign almost_empty_status_oe = almost_empty_status_oe_reg;
   // the one output not taken from a flop: output enable must not wait for a clock
   assign rd_data_oe = rown_reg && !out_en_n; //RULE11

   // checking
   logic [NQ-1:0] full_vec_d_reg;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) full_vec_d_reg <= '0;
      else full_vec_d_reg <= full_vec;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_rd_switch;
      rd_state_reg == RD_SW1 ##1 rd_state_reg == RD_SW2 ##1 rd_state_reg == RD_SW3
      ##1 rd_state_reg == RD_RUN;
   endsequence

   AST_FULL_LAG: assert property ( //RULE1
      ##3 queue_full_flag_n == !full_vec_d_reg[$past(wq_reg, 3)])
      else $error("full flag does not follow queue selected three clocks before");
   AST_NO_OVERFILL: assert property (acc_cnt_reg[wq_reg] <= QDEPTH_CNT) //RULE4
      else $error("write queue count passed its depth");
   AST_RD_SWITCH: assert property (rd_select |=> s_rd_switch) //RULE7
      else $error("read queue switch did not take four clocks");
   AST_NEW_FALLS: assert property ( //RULE2
      (in_sw3 && rown_new_reg && mem_cnt_reg[rq_new_reg] != CNT_ZERO)
      |=> !output_ready_n && rq_reg == $past(rq_new_reg))
      else $error("new queue word did not fall through");
   AST_OLD_WORD: assert property ( //RULE3
      (in_sw2 && rown_reg && mem_cnt_reg[rq_reg] != CNT_ZERO)
      |=> mem_cnt_reg[$past(rq_reg)] == $past(mem_cnt_reg[rq_reg]) - CNT_ONE)
      else $error("no further word from previous queue");
   AST_LAST_WORD: assert property ( //RULE8
      (rd_state_reg == RD_RUN && consume && mem_cnt_reg[rq_reg] == CNT_ZERO)
      |=> output_ready_n && $stable(rd_data))
      else $error("last word not held with ready high");
   AST_HOLD: assert property ( //RULE10
      (rd_en_n && rd_state_reg == RD_RUN && !output_ready_n) |=> $stable(rd_data))
      else $error("output word changed while reads disabled");
   AST_AE_LAT: assert property ( //RULE18
      (rd_state_reg == RD_RUN && fetch && mem_cnt_reg[rq_reg] == AE_OFFSET + CNT_ONE
       && rd_state_next == RD_RUN) |-> ##3 !almost_empty_flag_n)
      else $error("almost empty not asserted two clocks after read");
   AST_AF_LAT: assert property ( //RULE17
      (accept && wq_p1_reg == wq_reg && wr_select == 1'b0
       && acc_cnt_reg[wq_reg] == QDEPTH_CNT - AF_OFFSET - CNT_ONE
       && !(fetch && fetch_q == wq_reg)) |-> ##3 !almost_full_flag_n)
      else $error("almost full not asserted two clocks after write");
   AST_STATUS_LAT: assert property ( //RULE21
      full_status_strobe |-> ##3 almost_full_status_oe == $past(wr_hit, 3))
      else $error("full status bus ownership latency wrong");
   AST_FLOAT: assert property (!rown_reg |=> !almost_empty_flag_oe) //RULE24
      else $error("almost empty flag driven while not selected");
endmodule : mqsf_switch

// ===== tb/mqsf_host.sv
`timescale 1ns/100ps
module mqsf_host import mqsf_pkg::*; #(
   parameter logic [DEVW-1:0] DEV = DEV_ID_DEFAULT
) (
   input wire logic core_clk,
   output logic wr_en_n,
   output logic write_queue_addr_strobe,
   output logic full_status_strobe,
   output mqsf_qaddr_t wr_addr,
   output logic [DW-1:0] wr_data,
   output logic rd_en_n,
   output logic read_queue_addr_strobe,
   output logic empty_status_strobe,
   output mqsf_qaddr_t rd_addr,
   output logic out_en_n
);
   initial begin
      wr_en_n = 1'b1;
      write_queue_addr_strobe = 1'b0;
      full_status_strobe = 1'b0;
      wr_addr = '{dev: DEV, queue: 3'h0};
      wr_data = 36'h5a5a5a5a5;
      rd_en_n = 1'b1;
      read_queue_addr_strobe = 1'b0;
      empty_status_strobe = 1'b0;
      rd_addr = '{dev: DEV, queue: 3'h0};
      out_en_n = 1'b0;
   end

   // every request is set once per falling edge; an idle data bus is scrambled so a
   // late sample by the device shows up as a wrong word instead of a lucky match
   task automatic drive(input logic wen_n, input logic wstb, input logic fstb,
                        input logic ren_n, input logic rstb, input logic estb);
      @(negedge core_clk);
      wr_en_n = wen_n;
      write_queue_addr_strobe = wstb;
      full_status_strobe = fstb;
      rd_en_n = ren_n;
      read_queue_addr_strobe = rstb;
      empty_status_strobe = estb;
      if (wen_n) wr_data = ~wr_data;
   endtask : drive

   task automatic idle();
      drive(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
   endtask : idle

   task automatic wq_sel(input logic [QW-1:0] q, input logic [DEVW-1:0] dev = DEV);
      drive(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      wr_addr = '{dev: dev, queue: q};
   endtask : wq_sel

   // callers keep the two packet marker bits apart in every word
   task automatic wr(input logic [DW-1:0] d);
      drive(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      wr_data = d;
   endtask : wr

   task automatic rq_sel(input logic [QW-1:0] q, input logic [DEVW-1:0] dev = DEV);
      drive(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      rd_addr = '{dev: dev, queue: q};
   endtask : rq_sel

   task automatic rd();
      drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
   endtask : rd

   // address strobe of the same port stays low while a status word is picked
   task automatic fsel(input logic [DEVW-1:0] dev);
      drive(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      wr_addr.dev = dev;
   endtask : fsel

   task automatic esel(input logic [DEVW-1:0] dev);
      drive(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      rd_addr.dev = dev;
   endtask : esel

   // one enable shared by every device on the board, changed at any moment
   task automatic oe_set(input logic v);
      out_en_n = v;
   endtask : oe_set
endmodule : mqsf_host

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top import mqsf_pkg::*; ;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic wr_en_n, write_queue_addr_strobe, full_status_strobe, rd_en_n;
   logic read_queue_addr_strobe, empty_status_strobe, out_en_n;
   mqsf_qaddr_t wr_addr, rd_addr;
   logic [DW-1:0] wr_data, rd_data, last_word;
   logic queue_full_flag_n, almost_full_flag_n, almost_full_flag_oe, almost_full_status_oe;
   logic output_ready_n, almost_empty_flag_n, almost_empty_flag_oe, almost_empty_status_oe;
   logic rd_data_oe;
   logic [NQ-1:0] almost_full_status_bus, almost_empty_status_bus;
   logic [DW-1:0] exp_q0[$];
   logic [DW-1:0] exp_q1[$];
   int err_total = 0;
   int comparisons = 0;

   always #2.5 core_clk = ~core_clk;

   mqsf_switch u_mqsf_switch (.core_clk, .reset, .wr_en_n, .write_queue_addr_strobe,
      .full_status_strobe, .wr_addr, .wr_data, .queue_full_flag_n, .almost_full_flag_n,
      .almost_full_flag_oe, .almost_full_status_bus, .almost_full_status_oe, .rd_en_n,
      .read_queue_addr_strobe, .empty_status_strobe, .rd_addr, .out_en_n, .rd_data,
      .rd_data_oe, .output_ready_n, .almost_empty_flag_n, .almost_empty_flag_oe,
      .almost_empty_status_bus, .almost_empty_status_oe);

   mqsf_host u_host (.core_clk, .wr_en_n, .write_queue_addr_strobe, .full_status_strobe,
      .wr_addr, .wr_data, .rd_en_n, .read_queue_addr_strobe, .empty_status_strobe,
      .rd_addr, .out_en_n);

   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // back-to-back reads; each word is checked while it is still on the bus
   task automatic rd_n(input int n, ref logic [DW-1:0] q[$]);
      repeat (n) begin
         u_host.rd();
         chk(DW'(output_ready_n), 36'h0);
         chk(rd_data, q[0]);
         last_word = q.pop_front();
      end
      u_host.idle();
   endtask : rd_n

   task automatic give_verdict();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   initial begin
      #20000;
      err_total++;
      give_verdict();
   end

   initial begin
      repeat (2) @(negedge core_clk);
      chk(DW'({queue_full_flag_n, almost_full_flag_n, almost_full_flag_oe,
               almost_full_status_oe, output_ready_n, almost_empty_flag_n,
               almost_empty_flag_oe, almost_empty_status_oe, almost_full_status_bus,
               almost_empty_status_bus}), 36'h000c8ff00);
      chk(rd_data, 36'h0);
      reset = 1'b0;
      // fill queue 0, then one word too many
      u_host.wq_sel(3'h0);
      for (int i = 0; i < 16; i++) begin
         u_host.wr(36'h000000100 + DW'(i));
         exp_q0.push_back(36'h000000100 + DW'(i));
      end
      u_host.wr(36'h0000001ee);
      u_host.idle();
      chk(DW'(queue_full_flag_n), 36'h0);
      chk(DW'(almost_full_flag_oe), 36'h1);
      repeat (4) u_host.idle();
      // first read selection: fall-through three edges later
      u_host.rq_sel(3'h0);
      repeat (3) u_host.idle();
      chk(DW'(output_ready_n), 36'h1);
      u_host.idle();
      chk(DW'(output_ready_n), 36'h0);
      chk(rd_data, exp_q0[0]);
      repeat (2) u_host.idle();
      chk(rd_data, exp_q0[0]);
      chk(DW'({almost_empty_flag_n, almost_empty_flag_oe}), 36'h3);
      rd_n(1, exp_q0);
      chk(rd_data, exp_q0[0]);
      for (int n = 0; n < 4 && queue_full_flag_n !== 1'b1; n++) u_host.idle();
      chk(DW'(queue_full_flag_n), 36'h1);
      // the fall-through word and one read freed two places
      u_host.wr(36'h0000001fe);
      exp_q0.push_back(36'h0000001fe);
      u_host.wr(36'h0000001ff);
      exp_q0.push_back(36'h0000001ff);
      for (int n = 0; n < 4 && queue_full_flag_n !== 1'b0; n++) u_host.idle();
      chk(DW'(queue_full_flag_n), 36'h0);
      // write switch from the full queue to an empty one
      u_host.wq_sel(3'h1);
      repeat (3) begin
         u_host.idle();
         chk(DW'({queue_full_flag_n, almost_full_flag_n}), 36'h0);
      end
      u_host.idle();
      chk(DW'({queue_full_flag_n, almost_full_flag_n}), 36'h3);
      for (int i = 0; i < 14; i++) begin
         u_host.wr(36'h000000200 + DW'(i));
         exp_q1.push_back(36'h000000200 + DW'(i));
      end
      repeat (2) u_host.idle();
      chk(DW'(almost_full_flag_n), 36'h1);
      u_host.idle();
      chk(DW'(almost_full_flag_n), 36'h0);
      // status word ownership, then a change on consecutive cycles
      u_host.fsel(3'h0);
      repeat (2) begin
         u_host.idle();
         chk(DW'(almost_full_status_oe), 36'h0);
      end
      u_host.idle();
      chk(DW'(almost_full_status_oe), 36'h1);
      chk(DW'(almost_full_status_bus[7:1]), 36'h7e);
      u_host.fsel(3'h1);
      u_host.fsel(3'h0);
      u_host.idle();
      chk(DW'(almost_full_status_oe), 36'h1);
      u_host.idle();
      chk(DW'(almost_full_status_oe), 36'h0);
      u_host.idle();
      chk(DW'(almost_full_status_oe), 36'h1);
      u_host.esel(3'h0);
      repeat (2) begin
         u_host.idle();
         chk(DW'(almost_empty_status_oe), 36'h0);
      end
      u_host.idle();
      chk(DW'({almost_empty_status_oe, almost_empty_status_bus[7:1]}), 36'h81);
      // read switch while the old queue still holds words
      u_host.rq_sel(3'h1);
      repeat (2) begin
         u_host.idle();
         chk(rd_data, exp_q0[0]);
      end
      void'(exp_q0.pop_front());
      u_host.idle();
      chk(rd_data, exp_q0[0]);
      u_host.idle();
      chk(rd_data, exp_q1[0]);
      chk(DW'(output_ready_n), 36'h0);
      u_host.idle();
      chk(DW'({almost_empty_flag_n, almost_empty_flag_oe}), 36'h3);
      rd_n(14, exp_q1);
      chk(DW'(output_ready_n), 36'h1);
      chk(rd_data, last_word);
      for (int n = 0; n < 4 && almost_empty_flag_n !== 1'b0; n++) u_host.idle();
      chk(DW'(almost_empty_flag_n), 36'h0);
      // first word into an empty queue selected on both ports
      u_host.wr(36'h0000002aa);
      exp_q1.push_back(36'h0000002aa);
      for (int n = 0; n < 8 && output_ready_n !== 1'b0; n++) u_host.idle();
      chk(rd_data, exp_q1[0]);
      rd_n(1, exp_q1);
      chk(DW'(output_ready_n), 36'h1);
      // output enable between clock edges
      u_host.oe_set(1'b1);
      #1;
      chk(DW'(rd_data_oe), 36'h0);
      u_host.oe_set(1'b0);
      #1;
      chk(DW'(rd_data_oe), 36'h1);
      // queue 6 of another device on both ports: refused here, outputs float
      u_host.wq_sel(3'h6, 3'h5);
      u_host.rq_sel(3'h6, 3'h5);
      u_host.esel(3'h5);
      u_host.wr(36'h0000003cc);
      repeat (3) u_host.idle();
      chk(DW'({almost_full_flag_oe, almost_empty_flag_oe}), 36'h0);
      chk(DW'({rd_data_oe, almost_empty_status_oe}), 36'h0);
      // same queue of this device: the refused word must not fall through
      u_host.wq_sel(3'h6);
      u_host.rq_sel(3'h6);
      repeat (5) u_host.idle();
      chk(DW'({output_ready_n, rd_data_oe, almost_empty_flag_oe}), 36'h7);
      u_host.idle();
      give_verdict();
   end
endmodule : tb_top
